/* File: tone_switch_trigger_control_test.sv */
// Self-checking bench of the tone-switch trigger control.
// Assumes tsw_pkg, tsw_top and the neighbour model compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, v) begin check_count++; if ((v) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", nm, e, v); end end
module tone_switch_trigger_control_test;
  import tsw_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fgo, prev_lvl, s0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, freq_out, fval, master_freq_in;
  logic trig_in_pin, hold_in_pin, manual_trigger_key, manual_hold_key, marker_in;
  logic trig_prev_in, trig_next_in, trig_out, master_freq_stb, freq_stb, sync_out;
  logic burst_last_in, seq_end_in, sweep_start_in;
  logic [ADDR_W-1:0] wave_addr, a;
  int miscompares, check_count, cyc, n;

  tsw_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .trig_in_pin, .hold_in_pin, .manual_trigger_key, .manual_hold_key, .trig_prev_in, .trig_next_in,
    .trig_out, .master_freq_in, .master_freq_stb, .freq_out, .freq_stb, .marker_in, .burst_last_in,
    .seq_end_in, .sweep_start_in, .wave_addr, .sync_out);
  tsw_nbr_model nbr (.pclk, .presetn, .prev_lvl, .fgo, .fval, .trig_out, .trig_prev_in, .trig_next_in,
    .master_freq_in, .master_freq_stb);

  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Run is about 3300 cycles; a hang is cut well beyond that
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // One APB transfer, then an idle cycle so psel is never set twice in a step
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [31:0] cw(logic [1:0] m, logic [2:0] s, logic [2:0] w, logic [2:0] y,
    logic [1:0] t, logic [31:0] x);
    return {16'h0, t, y, w, 3'h0, s, m} | x;
  endfunction

  // Passing through a refused waveform parks the tone machine in idle first
  task automatic cfg(input logic [31:0] c);
    bus(1'b1, OFF_CTRL, c | 32'h00000200);
    bus(1'b1, OFF_CTRL, c);
  endtask

  task automatic still(input logic e);
    wt(5);
    a = wave_addr;
    wt(4);
    `CHK("frozen", e, wave_addr === a)
  endtask

  task automatic t_reset;
    bus(1'b0, OFF_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000000, q)
    bus(1'b0, OFF_TGEN, 32'h0);
    `CHK("tgen", 32'h000003E8, q)
    bus(1'b0, 8'h14, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("freq", 32'h00000001, freq_out)
    $display("test reset done");
  endtask

  task automatic t_fsk;
    logic [31:0] ex [3];
    ex = '{32'h01000000, TONE_INC_MAX, 32'h01000000};
    bus(1'b1, OFF_TONE, 32'h01000000);
    bus(1'b1, 8'h44, 32'hFFFFFFFF);
    bus(1'b1, OFF_TLEN, 32'h1);
    bus(1'b1, OFF_CTRL, cw(MD_FSK, SRC_REM, WV_STD, SY_WAVE, TO_WEND, 0));
    foreach (ex[i]) begin
      bus(1'b1, OFF_CMD, 32'h1);
      wt(6);
      `CHK("fsk tone", ex[i], freq_out)
    end
    $display("test fsk done");
  endtask

  task automatic t_refuse;
    logic [2:0] wv [3];
    wv = '{WV_PULSE, WV_PTRAIN, WV_SEQ};
    foreach (wv[i]) begin
      bus(1'b1, OFF_CTRL, cw(MD_FSK, SRC_REM, wv[i], SY_WAVE, TO_WEND, 0));
      bus(1'b1, OFF_CMD, 32'h1);
      wt(6);
      `CHK("refused tone", 32'h01000000, freq_out)
      bus(1'b0, OFF_STAT, 32'h0);
      `CHK("refused flag", 1'b1, q[9])
    end
    bus(1'b1, OFF_CTRL, cw(MD_FSK, SRC_REM, WV_ARB, SY_WAVE, TO_WEND, 0));
    bus(1'b1, OFF_CMD, 32'h1);
    bus(1'b1, OFF_CMD, 32'h1);
    wt(6);
    `CHK("arb tone", TONE_INC_MAX, freq_out)
    bus(1'b0, OFF_STAT, 32'h0);
    `CHK("arb flag", 1'b0, q[9])
    $display("test refuse done");
  endtask

  task automatic t_ext;
    cfg(cw(MD_TRIG, SRC_EXT, WV_STD, SY_WAVE, TO_WEND, 32'h1 << CT_POL));
    trig_in_pin <= 1'b0;
    wt(20);
    trig_in_pin <= 1'b1;
    wt(300);
    bus(1'b0, OFF_STAT, 32'h0);
    `CHK("rise ignored", 8'h21, q[7:0])
    trig_in_pin <= 1'b0;
    wt(300);
    bus(1'b0, OFF_STAT, 32'h0);
    `CHK("fall advances", 8'h20, q[7:0])
    trig_in_pin <= 1'b1;
    $display("test triggered done");
  endtask

  task automatic t_gate;
    cfg(cw(MD_GATE, SRC_PREV, WV_STD, SY_WAVE, TO_WEND, 0));
    prev_lvl <= 1'b1;
    wt(10);
    bus(1'b0, OFF_STAT, 32'h0);
    `CHK("gate on", 8'h20, q[7:0])
    prev_lvl <= 1'b0;
    wt(300);
    bus(1'b0, OFF_STAT, 32'h0);
    `CHK("gate off", 8'h11, q[7:0])
    $display("test gated done");
  endtask

  task automatic t_hold;
    bus(1'b1, OFF_CTRL, cw(MD_OFF, SRC_KEY, WV_ARB, SY_WAVE, TO_WEND, 32'h1 << CT_HOLD_EN));
    hold_in_pin <= 1'b0;
    still(1'b1);
    manual_trigger_key <= 1'b1;
    wt(6);
    `CHK("restart", 12'h000, wave_addr)
    manual_trigger_key <= 1'b0;
    hold_in_pin <= 1'b1;
    still(1'b0);
    bus(1'b1, OFF_CTRL, cw(MD_OFF, SRC_KEY, WV_ARB, SY_WAVE, TO_WEND, 0));
    hold_in_pin <= 1'b0;
    still(1'b0);
    manual_hold_key <= 1'b1;
    still(1'b1);
    manual_hold_key <= 1'b0;
    bus(1'b1, OFF_CTRL, cw(MD_OFF, SRC_KEY, WV_ARB, SY_WAVE, TO_WEND, 32'h1 << CT_HOLD_REM));
    still(1'b1);
    hold_in_pin <= 1'b1;
    $display("test hold done");
  endtask

  task automatic t_sync;
    bus(1'b1, OFF_TLEN, 32'h0);
    bus(1'b1, OFF_CTRL, cw(MD_OFF, SRC_REM, WV_STD, SY_TRIG, TO_WEND, 32'h1 << CT_RGATE));
    wt(5);
    `CHK("trig sync high", 1'b1, sync_out)
    bus(1'b1, OFF_CTRL, cw(MD_OFF, SRC_REM, WV_STD, SY_TRIG, TO_WEND, 0));
    wt(5);
    `CHK("trig sync low", 1'b0, sync_out)
    bus(1'b1, OFF_CTRL, cw(MD_OFF, SRC_REM, WV_STD, SY_WAVE, TO_WEND, 0));
    n = 0;
    repeat (512) begin
      @(posedge pclk);
      n += int'(sync_out === 1'b1);
    end
    `CHK("square duty", 1'b1, n >= 254 && n <= 258)
    bus(1'b1, OFF_TGEN, 32'h1);
    bus(1'b1, OFF_CTRL, cw(MD_OFF, SRC_REM, WV_STD, SY_TGEN, TO_WEND, 0));
    wt(600);
    n = 0;
    s0 = sync_out;
    repeat (1000) begin
      @(posedge pclk);
      n += int'(sync_out !== s0);
      s0 = sync_out;
    end
    `CHK("tgen edges", 1'b1, n >= 3 && n <= 5)
    $display("test sync done");
  endtask

  task automatic t_link;
    bus(1'b1, OFF_CTRL, cw(MD_OFF, SRC_KEY, WV_STD, SY_WAVE, TO_MARK, 0));
    marker_in <= 1'b1;
    wt(5);
    `CHK("trig out mark", 1'b1, trig_out)
    marker_in <= 1'b0;
    wt(5);
    `CHK("trig out clear", 1'b0, trig_out)
    bus(1'b1, OFF_CTRL, cw(MD_OFF, SRC_KEY, WV_STD, SY_WAVE, TO_WEND, 32'h1 << CT_SLAVE));
    wt(4);
    fval <= 32'h00ABCDEF;
    fgo <= 1'b1;
    @(posedge pclk);
    fgo <= 1'b0;
    n = 0;
    repeat (6) begin
      @(posedge pclk);
      n += int'(freq_stb === 1'b1);
    end
    `CHK("slave freq", 32'h00ABCDEF, freq_out)
    `CHK("slave stb", 1, n)
    $display("test link done");
  endtask

  task automatic t_eng;
    logic [2:0] sy [3];
    logic [1:0] to [3];
    sy = '{SY_BURST, SY_SEQ, SY_SWEEP};
    to = '{TO_BURST, TO_SEQ, TO_MARK};
    foreach (sy[i]) begin
      bus(1'b1, OFF_CTRL, cw(MD_OFF, SRC_KEY, WV_STD, sy[i], to[i], 0));
      {burst_last_in, seq_end_in, sweep_start_in} <= 3'b100 >> i;
      wt(3);
      `CHK("engine sync high", 1'b1, sync_out)
      `CHK("engine trig high", i < 2, trig_out)
      {burst_last_in, seq_end_in, sweep_start_in} <= ~(3'b100 >> i);
      wt(3);
      `CHK("engine sync low", 1'b0, sync_out)
      `CHK("engine trig low", 1'b0, trig_out)
    end
    {burst_last_in, seq_end_in, sweep_start_in} <= 3'b000;
    $display("test engine done");
  endtask

  initial begin
    {psel, penable, pwrite, fgo, prev_lvl, marker_in, manual_trigger_key, manual_hold_key} = '0;
    {paddr, pwdata, fval} = '0;
    {burst_last_in, seq_end_in, sweep_start_in} = 3'b000;
    {trig_in_pin, hold_in_pin} = 2'b11;
    {miscompares, check_count, cyc} = '0;
    presetn = 1'b0;
    wt(4);
    presetn <= 1'b1;
    wt(2);
    t_reset();
    t_fsk();
    t_refuse();
    t_ext();
    t_gate();
    t_hold();
    t_sync();
    t_link();
    t_eng();
    stop_test();
  end
endmodule // tone_switch_trigger_control_test

/* File: tsw_nbr_model.sv */
// Neighbour channels and master channel facing one channel.
// Assumes the bench steers it on pclk; outputs change after rising edges.
`timescale 1ns/1ps
module tsw_nbr_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench steering
  input wire logic prev_lvl,
  input wire logic fgo,
  input wire logic [31:0] fval,
  // Channel side
  input wire logic trig_out,
  output logic trig_prev_in,
  output logic trig_next_in,
  output logic [31:0] master_freq_in,
  output logic master_freq_stb
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_in <= 1'b0;
      trig_next_in <= 1'b0;
      master_freq_in <= 32'h00000000;
      master_freq_stb <= 1'b0;
    end else begin
      trig_prev_in <= prev_lvl;
      trig_next_in <= trig_out; // Loop closed through the chain
      master_freq_stb <= fgo;
      // Value is only good with the strobe, so it churns otherwise
      master_freq_in <= fgo ? fval : ~master_freq_in;
    end
  end
endmodule // tsw_nbr_model

/* File: tsw_pkg.sv */
// Constants, register map and state codes of the tone-switch trigger control.
// Assumes a 50 MHz APB clock shared by the synthesis engine and neighbour channels.
package tsw_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_TGEN = 8'h08;
  localparam logic [7:0] OFF_TLEN = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_TONE = 8'h40;
  localparam logic [7:0] OFF_TONE_END = 8'h7C;
  // Control field positions
  localparam int CT_MODE = 0;
  localparam int CT_SRC = 2;
  localparam int CT_POL = 5;
  localparam int CT_HOLD_EN = 6;
  localparam int CT_HOLD_REM = 7;
  localparam int CT_WAVE = 8;
  localparam int CT_SYNC = 11;
  localparam int CT_TOUT = 14;
  localparam int CT_SLAVE = 16;
  localparam int CT_RGATE = 17;
  localparam int CT_W = 18;
  localparam int CMD_TRIG = 0;
  // Reset values
  localparam logic [CT_W-1:0] CTRL_RST = 18'h00000;
  localparam logic [24:0] TGEN_RST = 25'h00003E8;
  localparam logic [3:0] TLEN_RST = 4'h0;
  // Tone modes
  localparam logic [1:0] MD_OFF = 2'h0;
  localparam logic [1:0] MD_GATE = 2'h1;
  localparam logic [1:0] MD_TRIG = 2'h2;
  localparam logic [1:0] MD_FSK = 2'h3;
  // Trigger sources
  localparam logic [2:0] SRC_KEY = 3'h0;
  localparam logic [2:0] SRC_PREV = 3'h1;
  localparam logic [2:0] SRC_NEXT = 3'h2;
  localparam logic [2:0] SRC_TGEN = 3'h3;
  localparam logic [2:0] SRC_EXT = 3'h4;
  localparam logic [2:0] SRC_REM = 3'h5;
  // Waveform kinds
  localparam logic [2:0] WV_STD = 3'h0;
  localparam logic [2:0] WV_ARB = 3'h1;
  localparam logic [2:0] WV_PULSE = 3'h2;
  localparam logic [2:0] WV_PTRAIN = 3'h3;
  localparam logic [2:0] WV_SEQ = 3'h4;
  // Sync output choices
  localparam logic [2:0] SY_WAVE = 3'h0;
  localparam logic [2:0] SY_MARK = 3'h1;
  localparam logic [2:0] SY_BURST = 3'h2;
  localparam logic [2:0] SY_SEQ = 3'h3;
  localparam logic [2:0] SY_TRIG = 3'h4;
  localparam logic [2:0] SY_SWEEP = 3'h5;
  localparam logic [2:0] SY_PLOCK = 3'h6;
  localparam logic [2:0] SY_TGEN = 3'h7;
  // Trigger-out choices
  localparam logic [1:0] TO_WEND = 2'h0;
  localparam logic [1:0] TO_MARK = 2'h1;
  localparam logic [1:0] TO_SEQ = 2'h2;
  localparam logic [1:0] TO_BURST = 2'h3;
  // Tone list and synthesis
  localparam int TONES = 16;
  localparam int ARB_POINTS = 4096;
  localparam int ADDR_W = $clog2(ARB_POINTS);
  localparam logic [ADDR_W-1:0] SYNC_PTS = 12'h004;
  localparam longint TONE_MAX_HZ = 10_000_000;
  // 1 mHz lies below one phase step, so the smallest step stands for it
  localparam logic [31:0] TONE_INC_MIN = 32'h00000001;
  localparam logic [31:0] TONE_INC_MAX = 32'((TONE_MAX_HZ * 64'h100000000) / CLK_HZ);
  // Trigger generator
  localparam int TGEN_STEP_NS = 10_000;
  localparam int TGEN_TICK_CYC = (TGEN_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [8:0] TGEN_TICK_LAST = 9'(TGEN_TICK_CYC - 1);
  // Tone state machine
  typedef enum logic [3:0] {
    TS_IDLE = 4'b0001,
    TS_PLAY = 4'b0010,
    TS_PEND = 4'b0100,
    TS_STOP = 4'b1000
  } tsw_state_t;
endpackage

/* File: tsw_top.sv */
// Tone switching, trigger selection, hold and sync-out logic of one channel.
// Assumes APB master on pclk; neighbour triggers and engine flags are on pclk.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps

// How it works
// - Up to sixteen tones, clamped to legal range
// - Gated: play while true, stop at cycle end
// - Triggered: later edges switch at cycle end
// - FSK: later edges switch tone immediately
// - Pulse, train and sequence refuse tone switching
// - Phase accumulator addresses 4096 resampled points
// - Six selectable trigger sources
// - Internal square generator in 10us period steps
// - External trigger polarity selectable
// - Hold freezes playback, release resumes there
// - Hold also from key and remote bit
// - Key or remote trigger while held restarts at first point
// - Per-channel hold input enable
// - Waveform sync square or first-points pulse
// - Position markers follow stored marker bits
// - Burst-done sync marks final burst cycle
// - Sequence sync marks end of sequence
// - Trigger sync copies trigger; sweep start pulse
// - Phase-lock sync rises at zero phase
// - Takes neighbour triggers, drives trigger out
// - Trigger out chosen per channel
// - Slave follows every master frequency change
module tsw_top
  import tsw_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and keys, asynchronous
  input wire logic trig_in_pin,
  input wire logic hold_in_pin,
  input wire logic manual_trigger_key,
  input wire logic manual_hold_key,
  // Neighbour channels
  input wire logic trig_prev_in,
  input wire logic trig_next_in,
  output logic trig_out,
  input wire logic [31:0] master_freq_in,
  input wire logic master_freq_stb,
  output logic [31:0] freq_out,
  output logic freq_stb,
  // Synthesis engine
  input wire logic marker_in,
  input wire logic burst_last_in,
  input wire logic seq_end_in,
  input wire logic sweep_start_in,
  output logic [ADDR_W-1:0] wave_addr,
  output logic sync_out
);

  typedef struct packed {
    logic [CT_W-1:0] ctrl;
    logic [24:0] tgen_per;
    logic [3:0] tlen;
    logic [TONES-1:0][31:0] tones;
    logic [3:0] s1;
    logic [3:0] s2;
    logic trig_q;
    logic mtk_q;
    logic [31:0] acc;
    logic [3:0] idx;
    tsw_state_t fsm;
    logic [8:0] pre;
    logic [25:0] tcnt;
    logic tlev;
    logic [31:0] slave_inc;
    logic [31:0] prdata;
    logic sync_out;
    logic trig_out;
    logic [ADDR_W-1:0] wave_addr;
    logic [31:0] freq_out;
    logic freq_stb;
  } tsw_st_t;

  tsw_st_t r;
  tsw_st_t nx;

  logic [1:0] mode;
  logic [2:0] src;
  logic [2:0] wave;
  logic is_arb;
  logic refused;
  logic setup;
  logic access_ok;
  logic wr;
  logic mapped;
  logic rem_trig;
  logic ext_lvl;
  logic hold_pin;
  logic mtk_lvl;
  logic mhk_lvl;
  logic trig_lvl;
  logic rise;
  logic held;
  logic restart;
  logic running;
  logic [31:0] inc;
  logic [32:0] sum;
  logic wrap;
  logic advance;
  logic [3:0] idx_next;
  logic [31:0] wclamp;
  logic [31:0] rd;
  logic tick;
  logic htick;
  tsw_state_t fsm_nxt;

  localparam int TICK_GAP = TGEN_TICK_CYC - 1;

  assign mode = r.ctrl[CT_MODE +: 2];
  assign src = r.ctrl[CT_SRC +: 3];
  assign wave = r.ctrl[CT_WAVE +: 3];
  assign is_arb = (wave == WV_ARB);
  assign refused = (wave == WV_PULSE) || (wave == WV_PTRAIN) || (wave == WV_SEQ);

  // Zero-wait slave: read data is latched in the setup cycle
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign access_ok = psel && penable;
  assign mapped = (paddr[1:0] == 2'h0) && ((paddr <= OFF_STAT) ||
                  ((paddr >= OFF_TONE) && (paddr <= OFF_TONE_END)));
  assign pslverr = access_ok && !mapped;
  assign wr = access_ok && pwrite && mapped;
  assign rem_trig = wr && (paddr == OFF_CMD) && pwdata[CMD_TRIG];
  assign wclamp = (pwdata < TONE_INC_MIN) ? TONE_INC_MIN :
                  (pwdata > TONE_INC_MAX) ? TONE_INC_MAX : pwdata;

  // Only the second stage is read
  assign ext_lvl = r.s2[0] ^ r.ctrl[CT_POL];
  assign hold_pin = r.s2[1];
  assign mtk_lvl = r.s2[2];
  assign mhk_lvl = r.s2[3];

  always_comb begin
    case (src)
      SRC_KEY: trig_lvl = mtk_lvl;
      SRC_PREV: trig_lvl = trig_prev_in;
      SRC_NEXT: trig_lvl = trig_next_in;
      SRC_TGEN: trig_lvl = r.tlev;
      SRC_EXT: trig_lvl = ext_lvl;
      SRC_REM: trig_lvl = r.ctrl[CT_RGATE];
      default: trig_lvl = 1'b0;
    endcase
  end

  // A remote trigger command also counts as an edge of the remote source
  assign rise = (trig_lvl && !r.trig_q) || ((src == SRC_REM) && rem_trig);
  assign held = (r.ctrl[CT_HOLD_EN] && !hold_pin) || mhk_lvl || r.ctrl[CT_HOLD_REM];
  assign restart = held && ((mtk_lvl && !r.mtk_q) || rem_trig);
  assign running = (mode == MD_OFF) || refused || (r.fsm != TS_IDLE);
  assign inc = r.ctrl[CT_SLAVE] ? r.slave_inc : r.tones[r.idx];
  assign sum = {1'b0, r.acc} + {1'b0, inc};
  assign wrap = running && !held && sum[32];
  assign idx_next = (r.idx == r.tlen) ? 4'h0 : r.idx + 4'h1;
  assign tick = (r.pre == TGEN_TICK_LAST);
  // Half steps let a one-step period still make a square wave
  assign htick = tick || (r.pre == (TGEN_TICK_LAST >> 1));

  always_comb begin
    rd = 32'h00000000;
    if (paddr == OFF_CTRL) begin
      rd[CT_W-1:0] = r.ctrl;
    end else if (paddr == OFF_TGEN) begin
      rd[24:0] = r.tgen_per;
    end else if (paddr == OFF_TLEN) begin
      rd[3:0] = r.tlen;
    end else if (paddr == OFF_STAT) begin
      rd[11:0] = {trig_lvl, r.tlev, refused, held, r.fsm, r.idx};
    end else if (paddr >= OFF_TONE && paddr <= OFF_TONE_END) begin
      rd = r.tones[paddr[5:2]];
    end
  end

  // Tone sequencing
  always_comb begin
    advance = 1'b0;
    fsm_nxt = r.fsm;
    if (mode == MD_OFF || refused) begin
      fsm_nxt = TS_IDLE;
    end else begin
      case (r.fsm)
        TS_IDLE: begin
          if ((mode == MD_GATE) ? trig_lvl : rise) begin
            fsm_nxt = TS_PLAY;
          end
        end
        TS_PLAY: begin
          if (mode == MD_GATE && !trig_lvl) begin
            fsm_nxt = TS_STOP;
          end else if (mode == MD_TRIG && rise) begin
            fsm_nxt = TS_PEND;
          end else if (mode == MD_FSK && rise) begin
            advance = 1'b1;
          end
        end
        TS_PEND: begin
          if (mode != MD_TRIG) begin
            fsm_nxt = TS_PLAY;
          end else if (wrap) begin
            advance = 1'b1;
            fsm_nxt = TS_PLAY;
          end
        end
        TS_STOP: begin
          if (mode != MD_GATE || trig_lvl) begin
            fsm_nxt = TS_PLAY;
          end else if (wrap) begin
            advance = 1'b1;
            fsm_nxt = TS_IDLE;
          end
        end
        default: fsm_nxt = TS_IDLE;
      endcase
    end
  end

  always_comb begin
    nx.fsm = fsm_nxt;
    nx.ctrl = r.ctrl;
    nx.tgen_per = r.tgen_per;
    nx.tlen = r.tlen;
    nx.tones = r.tones;
    nx.prdata = setup ? rd : r.prdata;
    if (wr) begin
      if (paddr == OFF_CTRL) begin
        nx.ctrl = pwdata[CT_W-1:0];
      end else if (paddr == OFF_TGEN) begin
        nx.tgen_per = (pwdata[24:0] == 25'h0) ? 25'h0000001 : pwdata[24:0];
      end else if (paddr == OFF_TLEN) begin
        nx.tlen = pwdata[3:0];
      end else if (paddr >= OFF_TONE) begin
        nx.tones[paddr[5:2]] = wclamp;
      end
    end
    nx.s1 = {manual_hold_key, manual_trigger_key, hold_in_pin, trig_in_pin};
    nx.s2 = r.s1;
    nx.trig_q = trig_lvl;
    nx.mtk_q = mtk_lvl;
    nx.idx = advance ? idx_next : r.idx;
    if (r.idx > r.tlen) begin
      nx.idx = 4'h0;
    end
    // Phase accumulator: top bits address the 4096-point table
    if (restart) begin
      nx.acc = 32'h00000000;
    end else if (running && !held) begin
      nx.acc = sum[31:0];
    end else begin
      nx.acc = r.acc;
    end
    nx.wave_addr = nx.acc[31 -: ADDR_W];
    // Trigger generator square wave
    nx.pre = tick ? 9'h000 : r.pre + 9'h001;
    nx.tcnt = r.tcnt;
    nx.tlev = r.tlev;
    if (htick) begin
      nx.tcnt = (r.tcnt >= {r.tgen_per, 1'b0} - 26'h0000001) ? 26'h0000000 : r.tcnt + 26'h0000001;
      // Low for the first half period, high for the second
      nx.tlev = (nx.tcnt >= {1'b0, r.tgen_per}) ? 1'b1 : 1'b0;
    end
    nx.slave_inc = master_freq_stb ? master_freq_in : r.slave_inc;
    nx.freq_out = inc;
    nx.freq_stb = (inc != r.freq_out);
    case (r.ctrl[CT_SYNC +: 3])
      SY_WAVE: nx.sync_out = is_arb ? (r.wave_addr < SYNC_PTS) : !r.acc[31];
      SY_MARK: nx.sync_out = is_arb ? marker_in : wrap;
      SY_BURST: nx.sync_out = burst_last_in;
      SY_SEQ: nx.sync_out = seq_end_in;
      SY_TRIG: nx.sync_out = trig_lvl;
      SY_SWEEP: nx.sync_out = sweep_start_in;
      SY_PLOCK: nx.sync_out = !r.acc[31];
      SY_TGEN: nx.sync_out = r.tlev;
      default: nx.sync_out = 1'b0;
    endcase
    case (r.ctrl[CT_TOUT +: 2])
      TO_WEND: nx.trig_out = wrap;
      TO_MARK: nx.trig_out = marker_in;
      TO_SEQ: nx.trig_out = seq_end_in;
      TO_BURST: nx.trig_out = burst_last_in;
      default: nx.trig_out = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.tgen_per <= TGEN_RST;
      r.tlen <= TLEN_RST;
      r.fsm <= TS_IDLE;
      r.tones <= {TONES{TONE_INC_MIN}};
    end else begin
      r <= nx;
    end
  end

  assign prdata = r.prdata;
  assign sync_out = r.sync_out;
  assign trig_out = r.trig_out;
  assign wave_addr = r.wave_addr;
  assign freq_out = r.freq_out;
  assign freq_stb = r.freq_stb;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fsk_edge;
    mode == MD_FSK && !refused && r.fsm == TS_PLAY && rise;
  endsequence

  sequence s_trig_edge;
    mode == MD_TRIG && !refused && r.fsm == TS_PLAY && rise;
  endsequence

  sequence s_pend_hold;
    mode == MD_TRIG && r.fsm == TS_PEND && !wrap;
  endsequence

  a_tone_wrap_last: assert property (advance && r.idx == r.tlen |=> r.idx == 4'h0)
    else $error("tone index did not wrap to zero");
  a_fsk_switch_now: assert property (s_fsk_edge |=> r.idx != $past(r.idx) || $past(r.tlen) == 4'h0)
    else $error("fsk edge did not switch tone");
  a_trig_pend_go: assert property (s_trig_edge |=> r.fsm == TS_PEND)
    else $error("triggered edge not queued");
  a_trig_wait_end: assert property (s_pend_hold |=> $stable(r.idx))
    else $error("tone switched before cycle end");
  a_gate_stop_end: assert property (mode == MD_GATE && !refused && r.fsm == TS_STOP && !trig_lvl && wrap
    |=> r.fsm == TS_IDLE)
    else $error("gated tone did not stop at cycle end");
  a_refuse_idle: assert property (refused |=> r.fsm == TS_IDLE)
    else $error("tone switching ran on refused waveform");
  a_hold_freeze: assert property (held && !restart |=> $stable(r.acc))
    else $error("held waveform moved");
  a_hold_restart: assert property (restart |=> r.acc == 32'h00000000 && r.wave_addr == 12'h000)
    else $error("held trigger did not restart playback");
  a_sync_trig_copy: assert property (r.ctrl[CT_SYNC +: 3] == SY_TRIG && $stable(r.ctrl)
    |=> sync_out == $past(trig_lvl))
    else $error("trigger sync does not follow trigger");
  a_slave_follow: assert property (r.ctrl[CT_SLAVE] && master_freq_stb ##1 !master_freq_stb
    |=> freq_out == $past(master_freq_in, 2))
    else $error("slave did not follow master frequency");
  a_tgen_tick_len: assert property (tick |=> r.pre == 9'h000 ##[TICK_GAP:TICK_GAP] tick)
    else $error("trigger generator step length wrong");
  a_tone_clamp: assert property (r.tones[r.idx] <= TONE_INC_MAX && r.tones[r.idx] >= TONE_INC_MIN)
    else $error("tone word out of range");

endmodule // tsw_top
